// File: hdl/mirw_regs.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "mirw_consts.svh"
//
// Contract
// RULE1 - read-only byte mirrors bits 7,6 of the four data-access registers
// RULE2 - reading the monitor byte offset returns last received monitor byte
// RULE3 - writing the monitor byte offset loads next byte to transmit
// RULE4 - monitor status upper nibble: received, end, acked, abort; low nibble zero
// RULE5 - receive irq enable 0 suppresses byte-received flag
// RULE6 - ack control 0: ack bit high, flag only for first packet byte
// RULE7 - ack control 1: ack bit per handshake, flag for every byte
// RULE8 - one enable gates end, acked and abort flags together
// RULE9 - valid control 0 holds valid bit 1; set drives it per handshake
// RULE10 - state byte shows transmit active at bit 2, time-out enable at bit 0
// RULE11 - config bit 0 enables monitor time-out
// RULE12 - top status holds six source flags in bits 5..0, upper zero
// RULE13 - reading top status clears nothing; source reads clear flags
// RULE14 - monitor summary flag sets whenever monitor status changes
// RULE15 - auxiliary summary set by wake, watchdog, timer1, timer2 events
// RULE16 - set top mask bit hides flag but keeps it pending; masks reset 1
// RULE17 - ci change flag shows even when masked, but raises no interrupt
// RULE18 - auxiliary mask hides auxiliary flags while keeping them pending
// RULE19 - watchdog expiry sets overflow flag and issues reset pulse
// RULE20 - host must kick 1,0 then 0,1 within every 128 ms
// RULE21 - missed kick sequence expires watchdog: flag plus reset pulse
// RULE22 - mode byte: kicks at 4,3, clock select 2, reset source 1,0
// RULE23 - once watchdog selected, software cannot deactivate it
// RULE24 - reset pulse lasts between 125 and 250 microseconds
// RULE25 - interrupt high while any unmasked top flag is set
module mirw_regs #(
    parameter int WD_CYCLES   = `MIRW_WD_PERIOD_MS * 1000 * `MIRW_CLK_MHZ,
    parameter int RST_CYCLES  = `MIRW_RST_MIN_US * `MIRW_CLK_MHZ,
    parameter int MONITOR_TIMEOUT_ENABLE_FRAMES = `MIRW_MON_MONITOR_TIMEOUT_ENABLE_FRAMES
) (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire mirw_pkg::mirw_bus_req_t bus_req,
    output logic [7:0]                   bus_rdata,
    input  wire logic [7:0]              data_access_ctrl,
    input  wire mirw_pkg::mirw_mon_in_t  mon_in,
    output mirw_pkg::mirw_mon_out_t      mon_out,
    input  wire logic                    sync_transfer_irq,
    input  wire logic                    ci_change_irq,
    input  wire logic                    transceiver_irq,
    input  wire logic                    hdlc_d_irq,
    input  wire logic                    timer_one_irq,
    input  wire logic                    timer_two_irq,
    input  wire logic                    ext_wake_n,
    output logic                         irq,
    output logic                         reset_out,
    output logic                         clock_config_select
);
    import mirw_pkg::*;

    generate
        if (WD_CYCLES < 4 || RST_CYCLES < 2 || MONITOR_TIMEOUT_ENABLE_FRAMES < 1) begin : g_chk
            $error("mirw_regs: counts too small");
        end
    endgenerate

    // register state
    logic [7:0]     rx_byte_r;
    logic [7:0]     tx_byte_r;
    logic [7:0]     mon_stat_r;
    logic [7:0]     mon_ctrl_r;
    logic           monitor_timeout_enable_en_r;
    logic [7:0]     top_mask_r;
    logic [7:0]     sec_stat_r;
    logic [7:0]     sec_mask_r;
    logic [7:0]     mode_r;
    logic           mos_r;
    // monitor channel state
    logic           rx_mx_prev_r;
    logic           in_pkt_r;
    logic           ack_r;
    logic           tx_pend_r;
    mirw_tx_state_t tx_state_r;
    logic [7:0]     monitor_timeout_enable_cnt_r;
    logic [7:0]     tx_data_r;
    logic           mx_r;
    logic           mr_r;
    // watchdog and reset pulse
    logic           wd_armed_r;
    logic           kick_stage_r;
    logic [31:0]    wd_cnt_r;
    logic [31:0]    pulse_cnt_r;
    logic           wake_s1_r;
    logic           wake_s2_r;
    logic           wake_prev_r;
    logic           ci_prev_r;

    // decodes
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic wr_mon_byte, wr_mon_ctrl, wr_mon_cfg, wr_top, wr_sec, wr_mode;
    logic rd_mon_stat, rd_sec;
    assign wr_mon_byte = bus_req.wr && hit(bus_req.addr, `MIRW_OFS_MON_BYTE);
    assign wr_mon_ctrl = bus_req.wr && hit(bus_req.addr, `MIRW_OFS_MON_CTRL);
    assign wr_mon_cfg  = bus_req.wr && hit(bus_req.addr, `MIRW_OFS_MON_STATE);
    assign wr_top      = bus_req.wr && hit(bus_req.addr, `MIRW_OFS_TOP_IRQ);
    assign wr_sec      = bus_req.wr && hit(bus_req.addr, `MIRW_OFS_SEC_IRQ);
    assign wr_mode     = bus_req.wr && hit(bus_req.addr, `MIRW_OFS_GEN_MODE);
    assign rd_mon_stat = bus_req.rd && hit(bus_req.addr, `MIRW_OFS_MON_IRQ_STAT);
    assign rd_sec      = bus_req.rd && hit(bus_req.addr, `MIRW_OFS_SEC_IRQ);

    // monitor control fields
    logic rx_irq_en, rx_ack_ctrl, misc_irq_en, tx_valid_ctrl;
    assign rx_irq_en     = mon_ctrl_r[`MIRW_MOC_RX_IRQ_EN];
    assign rx_ack_ctrl   = mon_ctrl_r[`MIRW_MOC_RX_ACK_CTRL];
    assign misc_irq_en   = mon_ctrl_r[`MIRW_MOC_MISC_IRQ_EN];
    assign tx_valid_ctrl = mon_ctrl_r[`MIRW_MOC_TX_VALID_CTRL];

    // monitor receive: falling remote valid marks a new byte
    logic new_byte, end_rx;
    assign new_byte = mon_in.frame && !mon_in.mx && rx_mx_prev_r;
    assign end_rx   = mon_in.frame && mon_in.mx && rx_mx_prev_r && in_pkt_r;

    // monitor transmit events
    logic ack_seen, monitor_timeout_enable_hit;
    assign ack_seen = mon_in.frame && tx_state_r == MIRW_TX_WAIT && !mon_in.mr;
    assign monitor_timeout_enable_hit = mon_in.frame && tx_state_r == MIRW_TX_WAIT && mon_in.mr
                      && monitor_timeout_enable_en_r && monitor_timeout_enable_cnt_r == 8'(MONITOR_TIMEOUT_ENABLE_FRAMES - 1);

    // flag events, each gated by its enable
    logic [7:0] mon_evt;
    always_comb begin
        mon_evt = 8'h00;
        // RULE5 RULE6 RULE7 byte-received gating
        mon_evt[`MIRW_MOS_BYTE_RX] = new_byte && rx_irq_en && (rx_ack_ctrl || !in_pkt_r);
        // RULE8 shared enable
        mon_evt[`MIRW_MOS_END_RX]  = end_rx && misc_irq_en;
        mon_evt[`MIRW_MOS_ACKED]   = ack_seen && misc_irq_en;
        mon_evt[`MIRW_MOS_ABORT]   = monitor_timeout_enable_hit && misc_irq_en;
    end

    // receive path sampling
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rx_mx_prev_r <= 1'b1;
            in_pkt_r     <= 1'b0;
            ack_r        <= 1'b0;
            rx_byte_r    <= `MIRW_RST_MON_RX;
        end else if (mon_in.frame) begin
            rx_mx_prev_r <= mon_in.mx;
            if (new_byte) begin
                // RULE2 capture received byte
                rx_byte_r <= mon_in.data;
                in_pkt_r  <= 1'b1;
                ack_r     <= 1'b1;
            end else if (mon_in.mx) begin
                ack_r <= 1'b0;
                if (end_rx) begin
                    in_pkt_r <= 1'b0;
                end
            end
        end
    end

    // transmit byte and pending flag; a write beside the pickup by the sequencer wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_byte_r <= `MIRW_RST_MON_TX;
            tx_pend_r <= 1'b0;
        end else if (wr_mon_byte) begin
            // RULE3 load next transmit byte
            tx_byte_r <= bus_req.wdata;
            tx_pend_r <= 1'b1;
        end else if (mon_in.frame && tx_pend_r &&
                     (tx_state_r == MIRW_TX_IDLE || tx_state_r == MIRW_TX_GAP)) begin
            tx_pend_r <= 1'b0;
        end
    end

    // transmit sequencer: gap frame with valid high between bytes
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tx_state_r   <= MIRW_TX_IDLE;
            monitor_timeout_enable_cnt_r   <= 8'h00;
            tx_data_r    <= `MIRW_RST_MON_TX;
        end else if (mon_in.frame) begin
            unique case (tx_state_r)
                MIRW_TX_IDLE, MIRW_TX_GAP: begin
                    monitor_timeout_enable_cnt_r <= 8'h00;
                    if (tx_pend_r) begin
                        tx_state_r   <= MIRW_TX_WAIT;
                        tx_data_r    <= tx_byte_r;
                    end else begin
                        tx_state_r <= MIRW_TX_IDLE;
                    end
                end
                MIRW_TX_WAIT: begin
                    if (ack_seen || monitor_timeout_enable_hit) begin
                        tx_state_r <= MIRW_TX_GAP;
                    end else if (monitor_timeout_enable_en_r) begin
                        monitor_timeout_enable_cnt_r <= monitor_timeout_enable_cnt_r + 8'h01;
                    end
                end
            endcase
        end
    end

    // handshake bits, registered
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mx_r <= 1'b1;
            mr_r <= 1'b1;
        end else begin
            // RULE9 valid bit control
            mx_r <= tx_valid_ctrl ? !(tx_state_r == MIRW_TX_WAIT) : 1'b1;
            // RULE6 RULE7 ack bit control
            mr_r <= rx_ack_ctrl ? !ack_r : 1'b1;
        end
    end

    // one driver for the whole output struct, so no field has two writers
    assign mon_out = '{data: tx_data_r, mx: mx_r, mr: mr_r};

    // monitor status: read clears, a new event wins
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mon_stat_r <= `MIRW_RST_MON_IRQ_STAT;
            mos_r      <= 1'b0;
        end else begin
            // RULE4 upper nibble only
            mon_stat_r <= ((rd_mon_stat ? 8'h00 : mon_stat_r) | mon_evt) & 8'hF0;
            // RULE14 summary on any change
            if (|mon_evt) begin
                mos_r <= 1'b1;
            end else if (rd_mon_stat) begin
                mos_r <= 1'b0;
            end
        end
    end

    // control and config registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mon_ctrl_r <= `MIRW_RST_MON_CTRL;
            monitor_timeout_enable_en_r  <= 1'b0;
            top_mask_r <= `MIRW_RST_TOP_MASK;
            sec_mask_r <= `MIRW_RST_SEC_MASK;
        end else begin
            if (wr_mon_ctrl) begin
                mon_ctrl_r <= bus_req.wdata & 8'h0F;
            end
            // RULE11 time-out enable
            if (wr_mon_cfg) begin
                monitor_timeout_enable_en_r <= bus_req.wdata[`MIRW_MST_MONITOR_TIMEOUT_ENABLE];
            end
            // RULE16 RULE18 masks, unused bits stuck at 1
            if (wr_top) begin
                top_mask_r <= bus_req.wdata | `MIRW_TOP_FORCED;
            end
            if (wr_sec) begin
                sec_mask_r <= bus_req.wdata | `MIRW_SEC_FORCED;
            end
        end
    end

    // external wake pin: two-stage sync, then falling edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wake_s1_r   <= 1'b1;
            wake_s2_r   <= 1'b1;
            wake_prev_r <= 1'b1;
            ci_prev_r   <= 1'b0;
        end else begin
            wake_s1_r   <= ext_wake_n;
            wake_s2_r   <= wake_s1_r;
            wake_prev_r <= wake_s2_r;
            ci_prev_r   <= ci_change_irq;
        end
    end

    logic wake_evt, ci_evt, wd_expire;
    assign wake_evt = wake_prev_r && !wake_s2_r;
    assign ci_evt   = ci_change_irq && !ci_prev_r;

    // general mode; reset source locks once watchdog is chosen
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r     <= `MIRW_RST_GEN_MODE;
            wd_armed_r <= 1'b0;
        end else if (wr_mode) begin
            // RULE22 field layout
            mode_r[7:2] <= {3'b000, bus_req.wdata[4:2]};
            // RULE23 ignore deactivation
            if (!wd_armed_r) begin
                mode_r[1:0] <= bus_req.wdata[1:0];
                wd_armed_r  <= bus_req.wdata[1:0] == `MIRW_RSS_WATCHDOG;
            end
        end
    end

    // kick detection; a write that breaks the sequence starts over
    logic kick_done;
    assign kick_done = wr_mode && kick_stage_r &&
                       !bus_req.wdata[`MIRW_GM_KICK_FIRST] &&
                       bus_req.wdata[`MIRW_GM_KICK_SECOND];

    // RULE20 RULE21 watchdog window
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            kick_stage_r <= 1'b0;
            wd_cnt_r     <= 32'h0000_0000;
        end else begin
            if (wr_mode) begin
                kick_stage_r <= bus_req.wdata[`MIRW_GM_KICK_FIRST] &&
                                !bus_req.wdata[`MIRW_GM_KICK_SECOND];
            end
            if (!wd_armed_r || kick_done || wd_expire) begin
                wd_cnt_r <= 32'h0000_0000;
            end else begin
                wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
            end
        end
    end
    assign wd_expire = wd_armed_r && wd_cnt_r == 32'(WD_CYCLES - 1);

    // RULE19 RULE24 reset pulse of fixed length
    logic pulse_start;
    assign pulse_start = wd_expire ||
                         (mode_r[1:0] == `MIRW_RSS_WAKE_CI && (wake_evt || ci_evt));
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pulse_cnt_r <= 32'h0000_0000;
            reset_out   <= 1'b0;
        end else if (pulse_start) begin
            pulse_cnt_r <= 32'(RST_CYCLES - 1);
            reset_out   <= 1'b1;
        end else if (pulse_cnt_r != 32'h0000_0000) begin
            pulse_cnt_r <= pulse_cnt_r - 32'h0000_0001;
        end else begin
            reset_out <= 1'b0;
        end
    end

    // RULE15 RULE19 secondary flags; unmasked bits clear on read
    logic [7:0] sec_evt;
    assign sec_evt = {2'b00, wake_evt, wd_expire, timer_two_irq, timer_one_irq, 2'b00};
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sec_stat_r <= 8'h00;
        end else begin
            sec_stat_r <= ((rd_sec ? (sec_stat_r & sec_mask_r) : sec_stat_r) | sec_evt);
        end
    end

    // RULE12 top status composition
    logic [7:0] top_raw, top_vis;
    assign top_raw = {2'b00, sync_transfer_irq, ci_change_irq,
                      |(sec_stat_r & ~sec_mask_r), transceiver_irq, mos_r, hdlc_d_irq};
    // RULE16 RULE17 masked bits hidden, ci change always shown
    assign top_vis = top_raw & ~(top_mask_r & ~(8'h01 << `MIRW_TOP_CI));

    // RULE25 RULE17 interrupt from unmasked flags only
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(top_raw & ~top_mask_r);
        end
    end

    // read mux; RULE13 top status read has no side effect
    logic [7:0] rd_mux;
    always_comb begin
        unique case (bus_req.addr)
            // RULE1 data-access mirror
            `MIRW_OFS_DATA_BIT_MON: rd_mux = data_access_ctrl;
            `MIRW_OFS_MON_BYTE:     rd_mux = rx_byte_r;
            `MIRW_OFS_MON_IRQ_STAT: rd_mux = mon_stat_r;
            `MIRW_OFS_MON_CTRL:     rd_mux = mon_ctrl_r;
            // RULE10 state byte
            `MIRW_OFS_MON_STATE:    rd_mux = {5'b00000, tx_state_r != MIRW_TX_IDLE,
                                              1'b0, monitor_timeout_enable_en_r};
            `MIRW_OFS_TOP_IRQ:      rd_mux = top_vis;
            `MIRW_OFS_SEC_IRQ:      rd_mux = sec_stat_r & ~sec_mask_r;
            `MIRW_OFS_GEN_MODE:     rd_mux = mode_r;
            default:                rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.rd) begin
            bus_rdata <= rd_mux;
        end
    end

    assign clock_config_select = mode_r[`MIRW_GM_CLK_CFG];

    // checks
    rd_latency_a: assert property (@(posedge core_clk) disable iff (!nrst) // read timing of the strobed port, not from the contract rules
        bus_req.rd |=> bus_rdata == $past(rd_mux))
        else $error("read data not one cycle after strobe");
    mon_summary_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE14
        |mon_evt |=> mos_r && (mon_stat_r & $past(mon_evt)) == $past(mon_evt))
        else $error("monitor summary not set on change");
    top_noclear_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
        (bus_req.rd && bus_req.addr == `MIRW_OFS_TOP_IRQ && mos_r) |=> mos_r)
        else $error("top status read cleared a flag");
    ack_const_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE6
        !rx_ack_ctrl ##1 !rx_ack_ctrl |-> mon_out.mr)
        else $error("ack bit not held high");
    valid_const_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE9
        !tx_valid_ctrl ##1 !tx_valid_ctrl |-> mon_out.mx)
        else $error("valid bit not held high");
    wd_locked_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE23
        wd_armed_r |=> wd_armed_r && mode_r[1:0] == `MIRW_RSS_WATCHDOG)
        else $error("watchdog deactivated by software");
    wd_expiry_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE21
        wd_expire |=> reset_out && sec_stat_r[`MIRW_SEC_WDOG])
        else $error("expiry without flag and pulse");
    pulse_len_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE24
        $rose(reset_out) |-> reset_out[*2])
        else $error("reset pulse too short");
    irq_level_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE25
        ##1 irq == $past(|(top_raw & ~top_mask_r)))
        else $error("interrupt output does not follow flags");
    ci_visible_a: assert property (@(posedge core_clk) disable iff (!nrst) // RULE17
        (bus_req.rd && bus_req.addr == `MIRW_OFS_TOP_IRQ && ci_change_irq)
        |=> bus_rdata[`MIRW_TOP_CI])
        else $error("ci change hidden by mask");

    byte_rx_c: cover property (@(posedge core_clk) disable iff (!nrst)
        new_byte ##[1:50] end_rx);
    tx_acked_c: cover property (@(posedge core_clk) disable iff (!nrst)
        wr_mon_byte ##[1:50] ack_seen);
    wd_kick_c: cover property (@(posedge core_clk) disable iff (!nrst)
        wd_armed_r && kick_done);
    wd_fire_c: cover property (@(posedge core_clk) disable iff (!nrst)
        wd_expire);

endmodule

// File: include/mirw_consts.svh
`ifndef MIRW_CONSTS_SVH
`define MIRW_CONSTS_SVH

// register offsets
`define MIRW_OFS_DATA_BIT_MON  8'h5B
`define MIRW_OFS_MON_BYTE      8'h5C
`define MIRW_OFS_MON_IRQ_STAT  8'h5D
`define MIRW_OFS_MON_CTRL      8'h5E
`define MIRW_OFS_MON_STATE     8'h5F
`define MIRW_OFS_TOP_IRQ       8'h60
`define MIRW_OFS_SEC_IRQ       8'h61
`define MIRW_OFS_GEN_MODE      8'h62

// reset values
`define MIRW_RST_DATA_BIT_MON  8'hFF
`define MIRW_RST_MON_RX        8'hFF
`define MIRW_RST_MON_TX        8'hFF
`define MIRW_RST_MON_IRQ_STAT  8'h00
`define MIRW_RST_MON_CTRL      8'h00
`define MIRW_RST_TOP_MASK      8'hFF
`define MIRW_RST_SEC_MASK      8'hFF
`define MIRW_RST_GEN_MODE      8'h00

// monitor irq status bits
`define MIRW_MOS_BYTE_RX       7
`define MIRW_MOS_END_RX        6
`define MIRW_MOS_ACKED         5
`define MIRW_MOS_ABORT         4
// monitor control bits
`define MIRW_MOC_RX_IRQ_EN     3
`define MIRW_MOC_RX_ACK_CTRL   2
`define MIRW_MOC_MISC_IRQ_EN   1
`define MIRW_MOC_TX_VALID_CTRL 0
// monitor state / config bits
`define MIRW_MST_TX_ACTIVE     2
`define MIRW_MST_MONITOR_TIMEOUT_ENABLE          0
// top status bits
`define MIRW_TOP_SYNC          5
`define MIRW_TOP_CI            4
`define MIRW_TOP_AUX           3
`define MIRW_TOP_TRAN          2
`define MIRW_TOP_MON           1
`define MIRW_TOP_HDLC          0
`define MIRW_TOP_FORCED        8'hC0
// secondary status bits
`define MIRW_SEC_WAKE          5
`define MIRW_SEC_WDOG          4
`define MIRW_SEC_TIMER2        3
`define MIRW_SEC_TIMER1        2
`define MIRW_SEC_FORCED        8'hC3
// general mode bits
`define MIRW_GM_KICK_FIRST     4
`define MIRW_GM_KICK_SECOND    3
`define MIRW_GM_CLK_CFG        2
`define MIRW_GM_RSS_HI         1
`define MIRW_GM_RSS_LO         0
`define MIRW_RSS_WATCHDOG      2'b11
`define MIRW_RSS_WAKE_CI       2'b10

// timing
`define MIRW_CLK_MHZ           200
`define MIRW_WD_PERIOD_MS      128
`define MIRW_RST_MIN_US        125
`define MIRW_RST_MAX_US        250
`define MIRW_MON_MONITOR_TIMEOUT_ENABLE_FRAMES   32

`endif

// File: include/mirw_pkg.sv
package mirw_pkg;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mirw_bus_req_t;

    // monitor channel, one sample per frame
    typedef struct packed {
        logic       frame;
        logic [7:0] data;
        logic       mx;
        logic       mr;
    } mirw_mon_in_t;

    typedef struct packed {
        logic [7:0] data;
        logic       mx;
        logic       mr;
    } mirw_mon_out_t;

    typedef enum logic [1:0] {
        MIRW_TX_IDLE,
        MIRW_TX_WAIT,
        MIRW_TX_GAP
    } mirw_tx_state_t;

endpackage

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import mirw_pkg::*;
    logic                core_clk;
    logic                nrst;
    mirw_bus_req_t       bus_req;
    logic [7:0]          bus_rdata;
    logic [7:0]          data_access_ctrl;
    mirw_mon_in_t        mon_in;
    mirw_mon_out_t       mon_out;
    logic                ci_change_irq;
    logic                sync_transfer_irq;
    logic                transceiver_irq;
    logic                timer_two_irq;
    logic                ext_wake_n;
    logic                hdlc_d_irq;
    logic                timer_one_irq;
    logic                irq;
    logic                reset_out;
    logic                clock_config_select;
    int                  n_mismatch = 0;
    int                  n_checks = 0;
    int                  cyc = 0;
    int                  n;

    // short watchdog and pulse counts keep the run small
    mirw_regs #(.WD_CYCLES(200), .RST_CYCLES(10), .MONITOR_TIMEOUT_ENABLE_FRAMES(4)) dut (
        .core_clk(core_clk), .nrst(nrst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .data_access_ctrl(data_access_ctrl), .mon_in(mon_in), .mon_out(mon_out),
        .sync_transfer_irq(sync_transfer_irq), .ci_change_irq(ci_change_irq),
        .transceiver_irq(transceiver_irq), .hdlc_d_irq(hdlc_d_irq),
        .timer_one_irq(timer_one_irq), .timer_two_irq(timer_two_irq),
        .ext_wake_n(ext_wake_n), .irq(irq), .reset_out(reset_out),
        .clock_config_select(clock_config_select));

    // 200 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard, well above the expected thousand or so cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(string what, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    // read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, bus_rdata);
    endtask

    // one monitor frame, fields only meaningful on the strobe
    task automatic frm(logic [7:0] d, logic x, logic r);
        @(posedge core_clk);
        mon_in <= '{frame: 1'b1, data: d, mx: x, mr: r};
        @(posedge core_clk);
        mon_in <= '{frame: 1'b0, data: ~d, mx: ~x, mr: ~r};
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset();
        rd(8'h5B, 8'hFF);
        rd(8'h5C, 8'hFF);
        rd(8'h5D, 8'h00);
        rd(8'h5F, 8'h00);
        rd(8'h60, 8'h00);
        rd(8'h61, 8'h00);
        rd(8'h62, 8'h00);
        chk("mx mr idle", 8'h03, {6'h00, mon_out.mx, mon_out.mr});
        data_access_ctrl <= 8'h96;
        rd(8'h5B, 8'h96);
    endtask

    task automatic t_top();
        hdlc_d_irq <= 1'b1;
        ci_change_irq <= 1'b1;
        sync_transfer_irq <= 1'b1;
        transceiver_irq <= 1'b1;
        rd(8'h60, 8'h10);
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(8'h60, 8'hDA);
        rd(8'h60, 8'h35);
        rd(8'h60, 8'h35);
        chk("irq open", 8'h01, {7'h00, irq});
        hdlc_d_irq <= 1'b0;
        sync_transfer_irq <= 1'b0;
        transceiver_irq <= 1'b0;
        // ci change still pending but masked: shown, yet no interrupt
        rd(8'h60, 8'h10);
        chk("irq clear", 8'h00, {7'h00, irq});
        wr(8'h60, 8'hF7);
        @(posedge core_clk);
        ci_change_irq <= 1'b0;
        {timer_one_irq, timer_two_irq} <= 2'b11;
        @(posedge core_clk);
        {timer_one_irq, timer_two_irq} <= 2'b00;
        rd(8'h61, 8'h00);
        wr(8'h61, 8'hFB);
        rd(8'h60, 8'h08);
        rd(8'h61, 8'h04);
        rd(8'h61, 8'h00);
        wr(8'h61, 8'hF3);
        rd(8'h61, 8'h08);
    endtask

    task automatic t_mon();
        wr(8'h60, 8'hFD);
        wr(8'h5E, 8'h0F);
        wr(8'h5C, 8'hA5);
        frm(8'hFF, 1'b1, 1'b1);
        chk("tx byte", 8'hA5, mon_out.data);
        chk("tx valid", 8'h00, {7'h00, mon_out.mx});
        rd(8'h5F, 8'h04);
        frm(8'hFF, 1'b1, 1'b0);
        rd(8'h60, 8'h02);
        rd(8'h5D, 8'h20);
        rd(8'h5D, 8'h00);
        wr(8'h5F, 8'h01);
        frm(8'hFF, 1'b1, 1'b1);
        rd(8'h5F, 8'h01);
        wr(8'h5C, 8'h5A);
        repeat (7) frm(8'hFF, 1'b1, 1'b1);
        rd(8'h5D, 8'h10);
        frm(8'h00, 1'b1, 1'b1);
        frm(8'h3C, 1'b0, 1'b1);
        chk("ack low", 8'h00, {7'h00, mon_out.mr});
        rd(8'h5C, 8'h3C);
        rd(8'h5D, 8'h80);
        frm(8'h00, 1'b1, 1'b1);
        frm(8'h00, 1'b1, 1'b1);
        rd(8'h5D, 8'h40);
        wr(8'h5E, 8'h08);
        frm(8'h11, 1'b0, 1'b1);
        chk("ack high", 8'h01, {7'h00, mon_out.mr});
        rd(8'h5D, 8'h80);
        frm(8'h00, 1'b1, 1'b1);
        frm(8'h22, 1'b0, 1'b1);
        rd(8'h5D, 8'h00);
        wr(8'h5E, 8'h04);
        repeat (2) frm(8'h00, 1'b1, 1'b1);
        frm(8'h33, 1'b0, 1'b1);
        rd(8'h5D, 8'h00);
    endtask

    task automatic t_wdog();
        wr(8'h62, 8'h04);
        rd(8'h62, 8'h04);
        chk("clk cfg", 8'h01, {7'h00, clock_config_select});
        wr(8'h62, 8'h07);
        repeat (4) begin
            repeat (120) @(posedge core_clk);
            wr(8'h62, 8'h17);
            wr(8'h62, 8'h0F);
            chk("no expiry", 8'h00, {7'h00, reset_out});
        end
        wr(8'h62, 8'h04);
        n = 0;
        while (reset_out !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("expiry", 8'h01, {7'h00, reset_out});
        n = 0;
        while (reset_out === 1'b1 && n < 50) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("pulse len", 8'd10, n[7:0]);
        @(posedge core_clk);
        ext_wake_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        ext_wake_n <= 1'b1;
        wr(8'h61, 8'hCF);
        rd(8'h61, 8'h30);
    endtask

    // main sequence
    initial begin
        nrst = 1'b0;
        bus_req = '0;
        mon_in = '{frame: 1'b0, data: 8'hFF, mx: 1'b1, mr: 1'b1};
        data_access_ctrl = 8'hFF;
        ci_change_irq = 1'b0;
        hdlc_d_irq = 1'b0;
        timer_one_irq = 1'b0;
        {sync_transfer_irq, transceiver_irq, timer_two_irq, ext_wake_n} = 4'b0001;
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        t_top();
        t_mon();
        t_wdog();
        conclude();
    end
endmodule
